// File: scg_core_model.sv
// Core-side model: halt pulses, wake requests, oscillator start-up
`timescale 1ns/10ps
module scg_core_model #(
    parameter int OSC_DLY = 5
) (
    // Controller side
    input  wire logic clk,
    input  wire logic core_halted,
    input  wire logic irq_service,
    // Core side
    output logic      halt_insn,
    output logic      wake_irq,
    output logic      osc_startup_done
);
    logic [7:0] osc_cnt = 8'h00;
    initial halt_insn = 1'b0;
    initial wake_irq = 1'b0;
    // ========================================
    // Oscillator
    // Stopped while asleep, so it never reports stable before a wake request
    always @(posedge clk) begin
        if (!core_halted)
            osc_cnt <= 8'h00;
        else if (wake_irq || osc_cnt != 8'h00)
            osc_cnt <= osc_cnt + 8'h01;
        if (irq_service)
            wake_irq <= 1'b0;
    end
    assign osc_startup_done = (osc_cnt >= 8'(OSC_DLY));
    // ========================================
    // Requests
    task automatic sleep_now();
        @(posedge clk);
        halt_insn <= 1'b1;
        @(posedge clk);
        halt_insn <= 1'b0;
    endtask
    task automatic wake_now();
        @(posedge clk);
        wake_irq <= 1'b1;
    endtask
endmodule // scg_core_model

// File: scg_ctrl.sv
// Sleep mode control and peripheral clock gating controller
// What this block does
// - Enabled ADC stays powered in every sleep
// - ADC off then on forces extended conversion
// - Comparator off in deep sleep modes unless on reference
// - Comparator on reference keeps reference powered
// - Fuse-enabled brown-out detector stays active
// - Reference powered exactly when a user needs
// - Enabled watchdog keeps running while asleep
// - Input buffers off when I/O, ADC clocks stop
// - Debug enabled keeps main oscillator running
// - Debug off by either fuse or disable bit
// - Sleep control register layout and reset
// - Mode select decodes six modes, two reserved
// - Halt sleeps only with sleep enable set
// - Clock gate register layout and reset
// - Two-wire gate bit stops its clock
// - Timer2 gated only in synchronous mode
// - Timer0, timer1 gate bits freeze timers
// - SPI and USART0 gate bits stop clocks
// - Gated ADC denies comparator the input mux
// - Gated peripheral frozen, registers inaccessible
// - Wake holds core four cycles after start-up
// - Standby wake completes within six cycles
// - Idle stops only CPU and flash clocks
`timescale 1ns/10ps

module scg_ctrl
    import scg_pkg::*;
(
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       srst,
    // Avalon-MM slave
    input  wire logic [scg_pkg::ADDR_W-1:0] address,
    input  wire logic                       read,
    input  wire logic                       write,
    input  wire logic [scg_pkg::DATA_W-1:0] writedata,
    input  wire logic [3:0]                 byteenable,
    output logic      [scg_pkg::DATA_W-1:0] readdata,
    output logic                            waitrequest,
    // CPU core
    input  wire logic                       halt_insn,
    input  wire logic                       wake_irq,
    input  wire logic                       osc_startup_done,
    output logic                            core_halted,
    output logic                            irq_service,
    // Analog and system status
    input  wire logic                       adc_enabled,
    input  wire logic                       adc_conv_start,
    input  wire logic                       comp_enabled,
    input  wire logic                       comp_uses_vref,
    input  wire logic [2:0]                 brownout_level_fuse,
    input  wire logic                       watchdog_enabled,
    input  wire logic                       timer2_async_select,
    input  wire logic                       debug_enable_fuse,
    input  wire logic                       jtag_enable_fuse,
    // Clock domain enables
    output logic                            cpu_clk_run,
    output logic                            flash_clk_run,
    output logic                            io_clk_run,
    output logic                            adc_clk_run,
    output logic                            async_clk_run,
    output logic                            main_osc_run,
    // Peripheral clock enables, also grant register access
    output logic                            two_wire_clk_run,
    output logic                            timer2_clk_run,
    output logic                            timer0_clk_run,
    output logic                            timer1_clk_run,
    output logic                            spi_clk_run,
    output logic                            usart0_clk_run,
    output logic                            adc_clk_gate_run,
    // Analog power and modes
    output logic                            adc_power,
    output logic                            adc_extended_conv,
    output logic                            comp_power,
    output logic                            comp_mux_allowed,
    output logic                            vref_power,
    output logic                            brownout_active,
    output logic                            watchdog_run,
    output logic                            digital_input_enable,
    output logic                            debug_active
);
    import scg_pkg::*;

    // ==========================================================
    // Helpers
    function automatic logic mode_reserved(input logic [2:0] m);
        return (m == MODE_RSVD_A) || (m == MODE_RSVD_B);
    endfunction

    function automatic logic mode_standby(input logic [2:0] m);
        return (m == MODE_STANDBY) || (m == MODE_EXT_STBY);
    endfunction

    // ==========================================================
    // Registers
    logic [REG_W-1:0] sleep_mode_control;
    logic [REG_W-1:0] peripheral_clock_gate_0;
    logic [REG_W-1:0] debug_control;
    logic             bus_ack;
    scg_state_t       state;
    logic [2:0]       wake_cnt;
    logic [2:0]       sleep_mode;
    logic             adc_power_q;

    logic [2:0]       sleep_mode_select;
    logic             sleep_enable;
    logic             debug_port_disable;
    logic             bus_req;
    logic             bus_wr;
    logic [IDX_W-1:0] reg_idx;
    logic [REG_W-1:0] wbyte;
    logic [REG_W-1:0] sleep_status;
    logic             asleep;
    logic             enter_sleep;

    assign sleep_mode_select  = sleep_mode_control[MODE_MSB:MODE_LSB];
    assign sleep_enable       = sleep_mode_control[SLEEP_EN_BIT];
    assign debug_port_disable = debug_control[DBG_DIS_BIT];
    assign reg_idx            = address[ADDR_W-1:2];
    assign wbyte              = writedata[REG_W-1:0];
    assign asleep             = (state == SCG_SLEEP);

    // ==========================================================
    // Avalon slave: one wait cycle, answer on the second cycle
    assign bus_req     = read | write;
    assign waitrequest = bus_req & ~bus_ack;
    assign bus_wr      = write & bus_ack & byteenable[0];

    always_ff @(posedge clk) begin
        if (srst) begin
            bus_ack <= 1'b0;
        end else begin
            bus_ack <= bus_req & ~bus_ack;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            readdata <= '0;
        end else if (read & ~bus_ack) begin
            readdata <= '0;
            unique case (reg_idx)
                SLEEP_CTRL_IDX: readdata[REG_W-1:0] <= sleep_mode_control;
                CLK_GATE0_IDX:  readdata[REG_W-1:0] <= peripheral_clock_gate_0;
                SLEEP_STAT_IDX: readdata[REG_W-1:0] <= sleep_status;
                DEBUG_CTRL_IDX: readdata[REG_W-1:0] <= debug_control;
                default:        readdata <= '0;
            endcase
        end
    end

    // Reserved bits are masked on write so they always read zero
    always_ff @(posedge clk) begin
        if (srst) begin
            sleep_mode_control <= SLEEP_CTRL_RST;
        end else if (bus_wr && reg_idx == SLEEP_CTRL_IDX) begin
            sleep_mode_control <= wbyte & SLEEP_CTRL_WMASK;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            peripheral_clock_gate_0 <= CLK_GATE0_RST;
        end else if (bus_wr && reg_idx == CLK_GATE0_IDX) begin
            peripheral_clock_gate_0 <= wbyte & CLK_GATE0_WMASK;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            debug_control <= DEBUG_CTRL_RST;
        end else if (bus_wr && reg_idx == DEBUG_CTRL_IDX) begin
            debug_control <= wbyte & DEBUG_CTRL_WMASK;
        end
    end

    always_comb begin
        sleep_status                                       = '0;
        sleep_status[STAT_ASLEEP_BIT]                      = asleep;
        sleep_status[STAT_MODE_LSB+2:STAT_MODE_LSB]        = sleep_mode;
        sleep_status[STAT_HALT_BIT]                        = core_halted;
        sleep_status[STAT_DBG_BIT]                         = debug_active;
        sleep_status[STAT_VREF_BIT]                        = vref_power;
    end

    // ==========================================================
    // Sleep and wake sequencer
    // A reserved code leaves the core running: the halt acts as a no-op
    assign enter_sleep = halt_insn & sleep_enable & ~mode_reserved(sleep_mode_select);

    always_ff @(posedge clk) begin
        if (srst) begin
            state    <= SCG_ACTIVE;
            wake_cnt <= '0;
        end else begin
            unique case (state)
                SCG_ACTIVE: begin
                    if (enter_sleep) begin
                        state <= SCG_SLEEP;
                    end
                end
                SCG_SLEEP: begin
                    if (wake_irq) begin
                        state    <= SCG_START;
                        wake_cnt <= '0;
                    end
                end
                SCG_START: begin
                    // Oscillator kept running in standby, so a fixed short start-up
                    if (mode_standby(sleep_mode)) begin
                        if (wake_cnt == STBY_OSC_LAST) begin
                            state    <= SCG_HALT;
                            wake_cnt <= '0;
                        end else begin
                            wake_cnt <= wake_cnt + 3'h1;
                        end
                    end else if (osc_startup_done) begin
                        state    <= SCG_HALT;
                        wake_cnt <= '0;
                    end
                end
                SCG_HALT: begin
                    if (wake_cnt == HALT_LAST) begin
                        state    <= SCG_ACTIVE;
                        wake_cnt <= '0;
                    end else begin
                        wake_cnt <= wake_cnt + 3'h1;
                    end
                end
            endcase
        end
    end

    // Mode is latched at entry so software writes while asleep cannot alter it
    always_ff @(posedge clk) begin
        if (srst) begin
            sleep_mode <= MODE_IDLE;
        end else if (state == SCG_ACTIVE && enter_sleep) begin
            sleep_mode <= sleep_mode_select;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irq_service <= 1'b0;
        end else begin
            irq_service <= (state == SCG_HALT) && (wake_cnt == HALT_LAST);
        end
    end

    assign core_halted = (state != SCG_ACTIVE);

    // ==========================================================
    // Clock domains per sleep mode
    always_comb begin
        cpu_clk_run   = ~core_halted;
        flash_clk_run = ~core_halted;
        io_clk_run    = 1'b1;
        adc_clk_run   = 1'b1;
        async_clk_run = 1'b1;
        main_osc_run  = 1'b1;
        if (state != SCG_ACTIVE && state != SCG_HALT) begin
            unique case (sleep_mode)
                MODE_IDLE: begin
                    io_clk_run  = 1'b1;
                    adc_clk_run = 1'b1;
                end
                MODE_ADC_NR: begin
                    io_clk_run  = 1'b0;
                end
                MODE_PWR_DOWN, MODE_STANDBY, MODE_RSVD_A, MODE_RSVD_B: begin
                    io_clk_run    = 1'b0;
                    adc_clk_run   = 1'b0;
                    async_clk_run = 1'b0;
                end
                MODE_PWR_SAVE, MODE_EXT_STBY: begin
                    io_clk_run  = 1'b0;
                    adc_clk_run = 1'b0;
                end
            endcase
            // Oscillator stays up in standby modes and whenever debug is live
            main_osc_run = mode_standby(sleep_mode) | debug_active
                           | (sleep_mode == MODE_IDLE) | (sleep_mode == MODE_ADC_NR);
        end
    end

    // ==========================================================
    // Peripheral clock gates
    // Gating only drops the enable, so peripheral state is held, not reset
    assign two_wire_clk_run = io_clk_run & ~peripheral_clock_gate_0[GATE_TWI_BIT];
    assign timer2_clk_run   = timer2_async_select ? async_clk_run
                            : (io_clk_run & ~peripheral_clock_gate_0[GATE_TIM2_BIT]);
    assign timer0_clk_run   = io_clk_run & ~peripheral_clock_gate_0[GATE_TIM0_BIT];
    assign timer1_clk_run   = io_clk_run & ~peripheral_clock_gate_0[GATE_TIM1_BIT];
    assign spi_clk_run      = io_clk_run & ~peripheral_clock_gate_0[GATE_SPI_BIT];
    assign usart0_clk_run   = io_clk_run & ~peripheral_clock_gate_0[GATE_USART0_BIT];
    assign adc_clk_gate_run = adc_clk_run & ~peripheral_clock_gate_0[GATE_ADC_BIT];

    // ==========================================================
    // Analog power
    // Sleep state is deliberately absent: the ADC stays up in every mode
    assign adc_power        = adc_enabled & ~peripheral_clock_gate_0[GATE_ADC_BIT];
    assign comp_mux_allowed = ~peripheral_clock_gate_0[GATE_ADC_BIT];
    assign comp_power       = comp_enabled & (~asleep | sleep_mode == MODE_IDLE
                              | sleep_mode == MODE_ADC_NR | comp_uses_vref);
    assign brownout_active  = (brownout_level_fuse != BOD_OFF_CODE);
    assign vref_power       = brownout_active | adc_power
                              | (comp_power & comp_uses_vref);
    assign watchdog_run     = watchdog_enabled;
    assign digital_input_enable = io_clk_run | adc_clk_run;
    assign debug_active     = debug_enable_fuse & jtag_enable_fuse & ~debug_port_disable;

    always_ff @(posedge clk) begin
        if (srst) begin
            adc_power_q <= 1'b0;
        end else begin
            adc_power_q <= adc_power;
        end
    end

    // Power-up sets the flag; if it meets a conversion start, the set wins
    always_ff @(posedge clk) begin
        if (srst) begin
            adc_extended_conv <= 1'b1;
        end else if (adc_power & ~adc_power_q) begin
            adc_extended_conv <= 1'b1;
        end else if (adc_conv_start) begin
            adc_extended_conv <= 1'b0;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sleep_gate_a: assert property (halt_insn && state == SCG_ACTIVE && !sleep_enable
        |=> state == SCG_ACTIVE) else $error("halt without sleep enable entered sleep");
    rsvd_nop_a: assert property (halt_insn && state == SCG_ACTIVE
        && mode_reserved(sleep_mode_select) |=> !core_halted) else $error("reserved mode slept");
    halt_four_a: assert property ($rose(state == SCG_HALT)
        |-> core_halted [*4] ##1 !core_halted) else $error("wake halt not four cycles");
    stby_wake_a: assert property (asleep && wake_irq && mode_standby(sleep_mode)
        |-> core_halted [*7] ##1 !core_halted) else $error("standby wake not six cycles");
    idle_clocks_a: assert property (asleep && sleep_mode == MODE_IDLE
        |-> !cpu_clk_run && io_clk_run && adc_clk_run) else $error("idle clocks wrong");
    comp_off_a: assert property (asleep && sleep_mode == MODE_PWR_DOWN && !comp_uses_vref
        |-> !comp_power) else $error("comparator on in power-down");
    vref_need_a: assert property (vref_power == (brownout_active || adc_power
        || (comp_power && comp_uses_vref))) else $error("reference power mismatch");
    ext_conv_a: assert property ($rose(adc_power) |=> adc_extended_conv)
        else $error("extended conversion not flagged");
    tim2_gate_a: assert property (peripheral_clock_gate_0[GATE_TIM2_BIT] && !timer2_async_select
        |-> !timer2_clk_run) else $error("timer2 not gated");
    rsvd_bits_a: assert property ((sleep_mode_control & ~SLEEP_CTRL_WMASK) == '0
        && (peripheral_clock_gate_0 & ~CLK_GATE0_WMASK) == '0) else $error("reserved bit set");
    bus_ans_a: assert property (bus_req && !bus_ack |=> !waitrequest)
        else $error("bus answer late");
    dbg_off_a: assert property (!jtag_enable_fuse |-> !debug_active)
        else $error("debug active with fuse cleared");

    sleep_enter_c: cover property (state == SCG_ACTIVE ##1 asleep);
    stby_wake_c:   cover property (asleep && wake_irq && mode_standby(sleep_mode));
    gate_write_c:  cover property (bus_wr && reg_idx == CLK_GATE0_IDX);
    rsvd_halt_c:   cover property (halt_insn && sleep_enable && mode_reserved(sleep_mode_select));

endmodule // scg_ctrl

// File: scg_pkg.sv
// Constants and types shared by the sleep and clock gating controller
package scg_pkg;

    // ==========================================================
    // Bus geometry
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int REG_W  = 8;
    localparam int IDX_W  = 8;

    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [IDX_W-1:0] SLEEP_CTRL_IDX = 8'h33;
    localparam logic [IDX_W-1:0] CLK_GATE0_IDX  = 8'h64;
    localparam logic [IDX_W-1:0] SLEEP_STAT_IDX = 8'h70;
    localparam logic [IDX_W-1:0] DEBUG_CTRL_IDX = 8'h71;

    // ==========================================================
    // Reset values and writable masks
    localparam logic [REG_W-1:0] SLEEP_CTRL_RST   = 8'h00;
    localparam logic [REG_W-1:0] CLK_GATE0_RST    = 8'h00;
    localparam logic [REG_W-1:0] DEBUG_CTRL_RST   = 8'h00;
    localparam logic [REG_W-1:0] SLEEP_CTRL_WMASK = 8'h0F;
    localparam logic [REG_W-1:0] CLK_GATE0_WMASK  = 8'hEF;
    localparam logic [REG_W-1:0] DEBUG_CTRL_WMASK = 8'h01;

    // ==========================================================
    // Field positions
    localparam int SLEEP_EN_BIT   = 0;
    localparam int MODE_LSB       = 1;
    localparam int MODE_MSB       = 3;
    localparam int GATE_ADC_BIT   = 0;
    localparam int GATE_USART0_BIT= 1;
    localparam int GATE_SPI_BIT   = 2;
    localparam int GATE_TIM1_BIT  = 3;
    localparam int GATE_TIM0_BIT  = 5;
    localparam int GATE_TIM2_BIT  = 6;
    localparam int GATE_TWI_BIT   = 7;
    localparam int DBG_DIS_BIT    = 0;
    localparam int STAT_ASLEEP_BIT= 0;
    localparam int STAT_MODE_LSB  = 1;
    localparam int STAT_HALT_BIT  = 4;
    localparam int STAT_DBG_BIT   = 5;
    localparam int STAT_VREF_BIT  = 6;

    // ==========================================================
    // Sleep mode codes
    localparam logic [2:0] MODE_IDLE      = 3'h0;
    localparam logic [2:0] MODE_ADC_NR    = 3'h1;
    localparam logic [2:0] MODE_PWR_DOWN  = 3'h2;
    localparam logic [2:0] MODE_PWR_SAVE  = 3'h3;
    localparam logic [2:0] MODE_RSVD_A    = 3'h4;
    localparam logic [2:0] MODE_RSVD_B    = 3'h5;
    localparam logic [2:0] MODE_STANDBY   = 3'h6;
    localparam logic [2:0] MODE_EXT_STBY  = 3'h7;

    localparam logic [2:0] BOD_OFF_CODE   = 3'h7;

    // ==========================================================
    // Wake-up timing in clock cycles
    localparam int         STBY_WAKE_CYCLES = 6;
    localparam int         WAKE_HALT_CYCLES = 4;
    localparam logic [2:0] HALT_LAST        = 3'(WAKE_HALT_CYCLES - 1);
    localparam logic [2:0] STBY_OSC_LAST    = 3'(STBY_WAKE_CYCLES - WAKE_HALT_CYCLES - 1);

    typedef enum logic [1:0] {
        SCG_ACTIVE,
        SCG_SLEEP,
        SCG_START,
        SCG_HALT
    } scg_state_t;

endpackage

// File: sleep_and_clock_gating_ctrl_tb.sv
// Testbench for the sleep and clock gating controller
`timescale 1ns/10ps
module sleep_and_clock_gating_ctrl_tb;
    import scg_pkg::*;
    localparam int OSC_DLY = 5;
    logic clk = 1'b0, srst = 1'b1, read = 1'b0, write = 1'b0, adc_enabled = 1'b0, adc_conv_start = 1'b0;
    logic comp_enabled = 1'b1, comp_uses_vref = 1'b0, watchdog_enabled = 1'b1, timer2_async_select = 1'b0;
    logic debug_enable_fuse = 1'b1, jtag_enable_fuse = 1'b1, halt_insn, wake_irq, osc_startup_done;
    logic [9:0] address = 10'h000;
    logic [31:0] writedata = 32'h0, readdata, q;
    logic [3:0] byteenable = 4'hF;
    logic [2:0] brownout_level_fuse = 3'h0;
    logic waitrequest, core_halted, irq_service, cpu_clk_run, flash_clk_run, io_clk_run, adc_clk_run;
    logic async_clk_run, main_osc_run, two_wire_clk_run, timer2_clk_run, timer0_clk_run, timer1_clk_run;
    logic spi_clk_run, usart0_clk_run, adc_clk_gate_run, adc_power, adc_extended_conv, comp_power;
    logic comp_mux_allowed, vref_power, brownout_active, watchdog_run, digital_input_enable, debug_active;
    int n, comparisons = 0, num_errors = 0;

    always #5 clk = ~clk;
    scg_ctrl i_dut (.*);
    scg_core_model #(.OSC_DLY(OSC_DLY)) i_core (.clk, .core_halted, .irq_service, .halt_insn, .wake_irq,
                                                .osc_startup_done);
    // ========================================
    // Tasks
    task automatic summarize();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        address <= a;
        write <= wr;
        read <= !wr;
        writedata <= {24'h0, d};
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] exp);
        bus(1'b0, a, 8'h00);
        chk(q, exp);
    endtask
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    // ========================================
    // Tests
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd(10'h0CC, 32'h0);
        rd(10'h190, 32'h0);
        chk(adc_extended_conv, 1);
        bus(1'b1, 10'h0CC, 8'hFF);
        rd(10'h0CC, 32'h0F);
        bus(1'b1, 10'h190, 8'hFF);
        rd(10'h190, 32'hEF);
        bus(1'b1, 10'h3FC, 8'hFF);
        rd(10'h3FC, 32'h0);
        chk({two_wire_clk_run, timer2_clk_run, timer0_clk_run, timer1_clk_run, spi_clk_run, usart0_clk_run,
             adc_clk_gate_run, comp_mux_allowed}, 0);
        @(posedge clk);
        timer2_async_select <= 1'b1;
        step();
        chk(timer2_clk_run, 1);
        bus(1'b1, 10'h190, 8'h00);
        #1 chk({two_wire_clk_run, timer0_clk_run, timer1_clk_run, spi_clk_run, usart0_clk_run}, 5'h1F);
        $display("register and gating test done");
        @(posedge clk);
        adc_conv_start <= 1'b1;
        @(posedge clk);
        adc_conv_start <= 1'b0;
        step();
        chk(adc_extended_conv, 0);
        @(posedge clk);
        adc_enabled <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk(adc_extended_conv, 1);
        chk(debug_active, 1);
        @(posedge clk);
        debug_enable_fuse <= 1'b0;
        step();
        chk(debug_active, 0);
        @(posedge clk);
        debug_enable_fuse <= 1'b1;
        jtag_enable_fuse <= 1'b0;
        step();
        chk(debug_active, 0);
        @(posedge clk);
        jtag_enable_fuse <= 1'b1;
        bus(1'b1, 10'h1C4, 8'h01);
        #1 chk(debug_active, 0);
        $display("analog and debug test done");
        for (int m = 0; m < 8; m++) begin
            bus(1'b1, 10'h0CC, {4'h0, 3'(m), 1'b1});
            i_core.sleep_now();
            #1 chk(core_halted, !(m inside {4, 5}));
            if (m inside {4, 5})
                continue;
            chk({cpu_clk_run, flash_clk_run, io_clk_run, adc_clk_run, async_clk_run, timer2_clk_run, main_osc_run,
                 digital_input_enable, comp_power},
                {2'b00, m == 0, m < 2, !(m inside {2, 6}), !(m inside {2, 6}), !(m inside {2, 3}), m < 2,
                 m < 2});
            chk({adc_power, watchdog_run, brownout_active, vref_power}, 4'hF);
            i_core.wake_now();
            n = 0;
            repeat (40) begin
                step();
                if (!core_halted)
                    break;
                n++;
            end
            chk(irq_service, 1);
            chk(m > 5 ? n == 6 : n inside {[OSC_DLY + 3:OSC_DLY + 5]}, 1);
            $display("sleep mode %0d test done", m);
        end
        bus(1'b1, 10'h1C4, 8'h00);
        bus(1'b1, 10'h0CC, 8'h05);
        comp_uses_vref <= 1'b1;
        i_core.sleep_now();
        #1 chk({main_osc_run, comp_power, vref_power}, 3'h7);
        rd(10'h1C0, 32'h75);
        i_core.wake_now();
        repeat (16) step();
        chk(core_halted, 0);
        $display("debug sleep test done");
        bus(1'b1, 10'h0CC, 8'h04);
        i_core.sleep_now();
        #1 chk(core_halted, 0);
        $display("sleep disabled test done");
        summarize();
    end
    // Tests need under two thousand ns; over fifteen times that cuts a hang short
    initial begin
        #30000;
        num_errors++;
        $display("ERROR at %0t: timeout", $time);
        summarize();
    end
endmodule // sleep_and_clock_gating_ctrl_tb
